/* File: ifcsc_consts.vh */
// constants of the four-channel bus switch control logic
`ifndef IFCSC_CONSTS_VH
`define IFCSC_CONSTS_VH

// control register layout
`define IFCSC_CTRL_RESET 8'h00
`define IFCSC_EN_LSB 0
`define IFCSC_EN_MSB 3
`define IFCSC_ST_LSB 4
`define IFCSC_ST_MSB 7
`define IFCSC_EN_RESET 4'h0

// address byte layout
`define IFCSC_RW_BIT 0
`define IFCSC_RW_READ 1'b1
`define IFCSC_PIN_LOW_BIT 1
`define IFCSC_PIN_HIGH_BIT 2
`define IFCSC_FIXED_LSB 3
`define IFCSC_FIXED_MSB 7
`define IFCSC_FIXED_ADDR 5'h15

// bit counting
`define IFCSC_BYTE_BITS 4'h8
`define IFCSC_CNT_ZERO 4'h0
`define IFCSC_CNT_ONE 4'h1

`endif

/* File: ifcsc_sync.v */
// two-flop synchroniser for pins entering the ref_clk domain
`timescale 1ns/1ns
`default_nettype none

module ifcsc_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [W-1:0] asyncIn,
    output wire [W-1:0] syncOut
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // only the second stage is visible to logic
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
        end
    end

    assign syncOut = sync_q;
endmodule

`default_nettype wire

/* File: ifcsc_top.v */
// bus-facing control logic of the four-channel switch: slave engine, register, interrupts
//
// Behaviour
// - after that missing acknowledge the device releases the data line
// - last address bit: 1 reads the control register, 0 writes it
// - of several written data bytes only the last one is kept
// - low nibble bit n connects channel n when set, disconnects when clear
// - a new channel selection takes effect only at the following stop
// - after reset all four enable bits are zero, no channel connected
// - any combination of channel-enable bits is honoured
// - interrupt output driven low while any interrupt input is asserted
// - interrupt detection works whether or not the channel is enabled
// - register bits 4 to 7 report channels 0 to 3 in order
// - status bits capture the input levels at the moment of a read
// - a status bit reads 1 when its channel has a pending interrupt
// - interrupt inputs may act as plain inputs, reported the same way
// - the one register is written and read over the upstream bus
// - slave address holds two bits from the two address select pins
// - reset returns bus engine and register to defaults, all channels off
`timescale 1ns/1ns
`default_nettype none
`include "ifcsc_consts.vh"

module ifcsc_top #(
    parameter [4:0] FIXED_ADDR = `IFCSC_FIXED_ADDR
) (
    input wire ref_clk,
    input wire rst_n,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire irq_in_ch0_n,
    input wire irq_in_ch1_n,
    input wire irq_in_ch2_n,
    input wire irq_in_ch3_n,
    input wire addr_select_pin_low,
    input wire addr_select_pin_high,
    output reg irq_out,
    output reg irq_out_oe_n,
    output reg chan0_connect,
    output reg chan1_connect,
    output reg chan2_connect,
    output reg chan3_connect
);
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_AACK = 7'h04;
    localparam [6:0] ST_WDATA = 7'h08;
    localparam [6:0] ST_WACK = 7'h10;
    localparam [6:0] ST_RDATA = 7'h20;
    localparam [6:0] ST_RACK = 7'h40;

    wire [1:0] busSync;
    wire [3:0] irqSync;
    wire [1:0] addrSync;
    wire sclS;
    wire sdaS;

    // bus lines idle high, so they come out of reset released
    ifcsc_sync #(.W(2), .RST_VAL(2'h3)) busSyncU (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn({scl_in, sda_in}),
        .syncOut(busSync)
    );

    ifcsc_sync #(.W(4), .RST_VAL(4'hF)) irqSyncU (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn({irq_in_ch3_n, irq_in_ch2_n, irq_in_ch1_n, irq_in_ch0_n}),
        .syncOut(irqSync)
    );

    ifcsc_sync #(.W(2), .RST_VAL(2'h0)) addrSyncU (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn({addr_select_pin_high, addr_select_pin_low}),
        .syncOut(addrSync)
    );

    assign sclS = busSync[1];
    assign sdaS = busSync[0];

    reg sclPrev_q;
    reg sdaPrev_q;
    reg [6:0] state_q;
    reg [6:0] state_d;
    reg [3:0] bitCnt_q;
    reg [3:0] bitCnt_d;
    reg [7:0] shift_q;
    reg [7:0] shift_d;
    reg readDir_q;
    reg readDir_d;
    reg [3:0] ctrlEn_q;
    reg [3:0] ctrlEn_d;
    reg newSel_q;
    reg newSel_d;
    reg masterAck_q;
    reg masterAck_d;
    reg sdaOeN_d;
    reg [3:0] chanEn_q;
    reg [3:0] chanEn_d;

    wire sclRise;
    wire sclFall;
    wire startSeen;
    wire stopSeen;
    wire [6:0] ownAddr;
    wire [3:0] irqPending;

    // start and stop are data edges while the clock stays high
    assign sclRise = sclS & ~sclPrev_q;
    assign sclFall = ~sclS & sclPrev_q;
    assign startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign stopSeen = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
    assign ownAddr = {FIXED_ADDR, addrSync[1], addrSync[0]};
    // pending means the input is pulled low; the enable bits play no part
    assign irqPending = ~irqSync;

    always @* begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        readDir_d = readDir_q;
        ctrlEn_d = ctrlEn_q;
        newSel_d = newSel_q;
        masterAck_d = masterAck_q;
        sdaOeN_d = sda_oe_n;
        chanEn_d = chanEn_q;
        if (stopSeen) begin
            state_d = ST_IDLE;
            sdaOeN_d = 1'b1;
            if (newSel_q) begin
                chanEn_d = ctrlEn_q;
            end
            newSel_d = 1'b0;
        end else if (startSeen) begin
            // a repeated start drops any transfer in progress
            state_d = ST_ADDR;
            bitCnt_d = `IFCSC_CNT_ZERO;
            sdaOeN_d = 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sdaOeN_d = 1'b1;
                end
                ST_ADDR: begin
                    if (sclRise && bitCnt_q != `IFCSC_BYTE_BITS) begin
                        shift_d = {shift_q[6:0], sdaS};
                        bitCnt_d = bitCnt_q + `IFCSC_CNT_ONE;
                    end else if (sclFall && bitCnt_q == `IFCSC_BYTE_BITS) begin
                        if (shift_q[7:1] == ownAddr) begin
                            readDir_d = (shift_q[`IFCSC_RW_BIT] == `IFCSC_RW_READ);
                            sdaOeN_d = 1'b0;
                            state_d = ST_AACK;
                        end else begin
                            // not our address: stay silent until the next start or stop
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (sclFall) begin
                        bitCnt_d = `IFCSC_CNT_ZERO;
                        if (readDir_q) begin
                            // input levels are frozen as the first data bit goes out
                            shift_d = {irqPending, ctrlEn_q};
                            sdaOeN_d = irqPending[3];
                            state_d = ST_RDATA;
                        end else begin
                            sdaOeN_d = 1'b1;
                            state_d = ST_WDATA;
                        end
                    end
                end
                ST_WDATA: begin
                    if (sclRise && bitCnt_q != `IFCSC_BYTE_BITS) begin
                        shift_d = {shift_q[6:0], sdaS};
                        bitCnt_d = bitCnt_q + `IFCSC_CNT_ONE;
                    end else if (sclFall && bitCnt_q == `IFCSC_BYTE_BITS) begin
                        // each byte overwrites the last; the upper nibble is dropped
                        ctrlEn_d = shift_q[`IFCSC_EN_MSB:`IFCSC_EN_LSB];
                        newSel_d = 1'b1;
                        sdaOeN_d = 1'b0;
                        state_d = ST_WACK;
                    end
                end
                ST_WACK: begin
                    // a stop normally follows here; further bytes are still taken
                    if (sclFall) begin
                        sdaOeN_d = 1'b1;
                        bitCnt_d = `IFCSC_CNT_ZERO;
                        state_d = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_d = bitCnt_q + `IFCSC_CNT_ONE;
                    end else if (sclFall) begin
                        if (bitCnt_q == `IFCSC_BYTE_BITS) begin
                            sdaOeN_d = 1'b1;
                            state_d = ST_RACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            sdaOeN_d = shift_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    sdaOeN_d = 1'b1;
                    if (sclRise) begin
                        masterAck_d = ~sdaS;
                    end else if (sclFall) begin
                        if (masterAck_q) begin
                            // fresh sample for every byte read in one transfer
                            shift_d = {irqPending, ctrlEn_q};
                            sdaOeN_d = irqPending[3];
                            bitCnt_d = `IFCSC_CNT_ZERO;
                            state_d = ST_RDATA;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    sdaOeN_d = 1'b1;
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            state_q <= ST_IDLE;
            bitCnt_q <= `IFCSC_CNT_ZERO;
            shift_q <= `IFCSC_CTRL_RESET;
            readDir_q <= 1'b0;
            ctrlEn_q <= `IFCSC_EN_RESET;
            newSel_q <= 1'b0;
            masterAck_q <= 1'b0;
            chanEn_q <= `IFCSC_EN_RESET;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
            irq_out <= 1'b0;
            irq_out_oe_n <= 1'b1;
            chan0_connect <= 1'b0;
            chan1_connect <= 1'b0;
            chan2_connect <= 1'b0;
            chan3_connect <= 1'b0;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            readDir_q <= readDir_d;
            ctrlEn_q <= ctrlEn_d;
            newSel_q <= newSel_d;
            masterAck_q <= masterAck_d;
            chanEn_q <= chanEn_d;
            // open drain: the line is only ever pulled low
            sda_out <= 1'b0;
            sda_oe_n <= sdaOeN_d;
            irq_out <= 1'b0;
            irq_out_oe_n <= &irqSync;
            chan0_connect <= chanEn_d[0];
            chan1_connect <= chanEn_d[1];
            chan2_connect <= chanEn_d[2];
            chan3_connect <= chanEn_d[3];
        end
    end
endmodule

`default_nettype wire

/* File: ifcsc_monitor.sv */
// assertion checker for the switch control block
`timescale 1ns/1ns
`default_nettype none
module ifcsc_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic irq_in_ch0_n,
    input wire logic irq_in_ch1_n,
    input wire logic irq_in_ch2_n,
    input wire logic irq_in_ch3_n,
    input wire logic irq_out,
    input wire logic irq_out_oe_n,
    input wire logic chan0_connect,
    input wire logic chan1_connect,
    input wire logic chan2_connect,
    input wire logic chan3_connect
);
    wire [3:0] irqN = {irq_in_ch3_n, irq_in_ch2_n, irq_in_ch1_n, irq_in_ch0_n};
    wire [3:0] chans = {chan3_connect, chan2_connect, chan1_connect, chan0_connect};
    logic sclQ = 1'b1;
    logic sdaQ = 1'b1;
    logic [3:0] sclAge = 4'hF;
    logic [3:0] stopAge = 4'hF;
    // ages saturate so a long idle never wraps into a false window
    always @(posedge ref_clk) begin
        sclQ <= scl_in;
        sdaQ <= sda_in;
        if (sclQ && !scl_in) sclAge <= 4'h0;
        else if (sclAge != 4'hF) sclAge <= sclAge + 4'h1;
        if (scl_in && sda_in && !sdaQ) stopAge <= 4'h0;
        else if (stopAge != 4'hF) stopAge <= stopAge + 4'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence anyIrq; (irqN != 4'hF)[*5]; endsequence
    sequence noIrq; (irqN == 4'hF)[*5]; endsequence
    chk_irq_low: assert property (anyIrq |-> !irq_out_oe_n)
        else $error("interrupt output not driven");
    chk_irq_high: assert property (noIrq |-> irq_out_oe_n)
        else $error("interrupt output driven while idle");
    chk_od_zero: assert property (!sda_out && !irq_out)
        else $error("open drain value not low");
    chk_reset_state: assert property (disable iff (1'b0)
        !rst_n |=> chans == 4'h0 && sda_oe_n && irq_out_oe_n) else $error("reset state wrong");
    chk_chan_stop: assert property ($changed(chans) |-> stopAge <= 4'h8)
        else $error("channels changed without stop");
    chk_sda_timing: assert property ($changed(sda_oe_n) |-> sclAge inside {[4'h2:4'h5]})
        else $error("data line changed off clock fall");
    chk_bit_stable: assert property ($rose(scl_in) |=> $stable(sda_oe_n)[*4])
        else $error("data line moved during clock high");
    chk_idle_release: assert property (scl_in[*8] |-> sda_oe_n)
        else $error("data line held while bus idle");
endmodule
bind ifcsc_top ifcsc_monitor u_ifcsc_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .irq_in_ch0_n(irq_in_ch0_n), .irq_in_ch1_n(irq_in_ch1_n),
    .irq_in_ch2_n(irq_in_ch2_n), .irq_in_ch3_n(irq_in_ch3_n),
    .irq_out(irq_out), .irq_out_oe_n(irq_out_oe_n),
    .chan0_connect(chan0_connect), .chan1_connect(chan1_connect),
    .chan2_connect(chan2_connect), .chan3_connect(chan3_connect));
`default_nettype wire

/* File: ifcsc_master.sv */
// upstream bus master model: link clock and open-drain data
`timescale 1ns/1ns
`default_nettype none
module ifcsc_master (
    input wire logic sdaBus,
    output logic scl,
    output logic sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // 800 ns bit; data moves 100 ns into the 400 ns low, sampled mid-high, late enough for device lag
    task automatic bitx(input logic b, output logic r);
        #100 sdaLow = !b;
        #300 scl = 1'b1;
        #200 r = sdaBus;
        #200 scl = 1'b0;
    endtask
    task automatic start();
        #100 sdaLow = 1'b0;
        #100 scl = 1'b1;
        #400 sdaLow = 1'b1;
        #400 scl = 1'b0;
    endtask
    // clock stays low as long as in a data bit, so the device drops its ack first
    task automatic stop();
        #100 sdaLow = 1'b1;
        #300 scl = 1'b1;
        #400 sdaLow = 1'b0;
        #200;
    endtask
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic rdByte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, r);
    endtask
endmodule
`default_nettype wire

/* File: ifcsc_top_tb_top.sv */
// self-checking bench for the switch control block
`timescale 1ns/1ns
`default_nettype none
`include "ifcsc_consts.vh"
module ifcsc_top_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] irqN = 4'hF;
    logic [1:0] pins = 2'h0;
    logic [3:0] expCh = 4'h0;
    logic scl, sdaLow, a;
    wire sdaOut, sdaOeN, irqOut, irqOeN;
    wire [3:0] chans;
    wire sdaBus = !sdaLow && (sdaOeN || sdaOut);
    int num_errors = 0;
    int checks_done = 0;
    initial begin
        forever #50 ref_clk = !ref_clk;
    end
    ifcsc_top u_ifcsc_top (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sdaBus), .sda_out(sdaOut), .sda_oe_n(sdaOeN),
        .irq_in_ch0_n(irqN[0]), .irq_in_ch1_n(irqN[1]), .irq_in_ch2_n(irqN[2]),
        .irq_in_ch3_n(irqN[3]), .addr_select_pin_low(pins[0]),
        .addr_select_pin_high(pins[1]), .irq_out(irqOut), .irq_out_oe_n(irqOeN),
        .chan0_connect(chans[0]), .chan1_connect(chans[1]),
        .chan2_connect(chans[2]), .chan3_connect(chans[3]));
    ifcsc_master u_ifcsc_master (.sdaBus(sdaBus), .scl(scl), .sdaLow(sdaLow));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // every transfer starts just after an edge, so no bus change races the sync flops
    task automatic align();
        @(posedge ref_clk);
        #10;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic regWrite(input logic [7:0] b1, input logic [7:0] b2);
        align();
        u_ifcsc_master.start();
        u_ifcsc_master.wrByte({`IFCSC_FIXED_ADDR, pins, 1'b0}, a);
        check({7'h00, a}, 8'h01);
        u_ifcsc_master.wrByte(b1, a);
        u_ifcsc_master.wrByte(b2, a);
        check({4'h0, chans}, {4'h0, expCh});
        u_ifcsc_master.stop();
        expCh = b2[3:0];
        repeat (8) @(posedge ref_clk);
        check({4'h0, chans}, {4'h0, expCh});
    endtask
    task automatic regRead(input logic [7:0] exp);
        logic [7:0] d;
        align();
        u_ifcsc_master.start();
        u_ifcsc_master.wrByte({`IFCSC_FIXED_ADDR, pins, 1'b1}, a);
        check({7'h00, a}, 8'h01);
        u_ifcsc_master.rdByte(1'b0, d);
        check(d, exp);
        u_ifcsc_master.rdByte(1'b1, d);
        check(d, exp);
        // a device that missed the nack would drive again a few edges after the fall
        repeat (4) @(posedge ref_clk);
        #10 check({7'h00, sdaOeN}, 8'h01);
        u_ifcsc_master.stop();
    endtask
    task automatic t_write();
        logic [7:0] v;
        for (int i = 0; i < 16; i++) begin
            v = {~4'(i), 4'(i)};
            regWrite(~v, v);
            regRead({4'h0, 4'(i)});
        end
        $display("write test done");
    endtask
    task automatic t_irq();
        logic [3:0] p;
        regWrite(8'h0F, 8'h00);
        for (int i = 0; i < 5; i++) begin
            p = (i < 4) ? 4'h1 << i : 4'h9;
            @(posedge ref_clk);
            #10 irqN = ~p;
            repeat (6) @(posedge ref_clk);
            check({7'h00, irqOeN}, 8'h00);
            regRead({p, expCh});
            regWrite(8'h00, {4'h0, p});
            check({7'h00, irqOeN}, 8'h00);
            @(posedge ref_clk);
            #10 irqN = 4'hF;
            repeat (6) @(posedge ref_clk);
            check({7'h00, irqOeN}, 8'h01);
        end
        $display("interrupt test done");
    endtask
    task automatic t_addr();
        for (int v = 0; v < 4; v++) begin
            @(posedge ref_clk);
            #10 pins = 2'(v);
            for (int j = 1; j < 4; j++) begin
                u_ifcsc_master.start();
                u_ifcsc_master.wrByte({`IFCSC_FIXED_ADDR, pins ^ 2'(j), 1'b0}, a);
                check({7'h00, a}, 8'h00);
                u_ifcsc_master.stop();
            end
            regWrite(8'h00, 8'(v));
        end
        $display("address test done");
    endtask
    task automatic t_reset();
        check({3'h0, irqOeN, chans}, 8'h10);
        regRead(`IFCSC_CTRL_RESET);
        regWrite(8'h00, 8'h03);
        @(posedge ref_clk);
        #10 rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #10 rst_n = 1'b1;
        expCh = 4'h0;
        check({4'h0, chans}, 8'h00);
        repeat (3) @(posedge ref_clk);
        regRead(`IFCSC_CTRL_RESET);
        $display("reset test done");
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        #10 rst_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_write();
        t_irq();
        t_addr();
        give_verdict();
    end
    initial begin
        #5000000;
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
